// ### include/sdi_pkg.sv
// package for the system decode and interrupt block
// assumes a single 50 MHz clock and an axi4-lite register port
package sdi_pkg;
	// register byte offsets, chosen locally inside each block's window (decoder 0x00-0x14, interrupt 0x20-0x34)
	localparam logic [7:0] SDI_OFS_PEND = 8'h20;
	localparam logic [7:0] SDI_OFS_MASK = 8'h24;
	localparam logic [7:0] SDI_OFS_FIQSEL = 8'h28;
	localparam logic [7:0] SDI_OFS_FIQVEC = 8'h2c;
	localparam logic [7:0] SDI_OFS_IRQVEC = 8'h30;
	localparam logic [7:0] SDI_OFS_CTRL = 8'h34;
	localparam logic [7:0] SDI_OFS_FLBASE = 8'h00;
	localparam logic [7:0] SDI_OFS_ROMBASE = 8'h04;
	localparam logic [7:0] SDI_OFS_RAMBASE = 8'h08;
	localparam logic [7:0] SDI_OFS_SIZES = 8'h0c;
	localparam logic [7:0] SDI_OFS_PRIV = 8'h10;
	localparam logic [7:0] SDI_OFS_FAULT = 8'h14;
	// block bases at the top of the space
	localparam logic [31:0] SDI_CIM_BASE = 32'hffffff00;
	localparam logic [31:0] SDI_DEC_BASE = 32'hfffffe00;
	localparam logic [31:0] SDI_CIM_LO = 32'hffffff20;
	localparam logic [31:0] SDI_CIM_HI = 32'hffffff37;
	// memory map defaults
	localparam logic [31:0] SDI_BOOT_ROM_BASE = 32'h00000000;
	localparam logic [31:0] SDI_BOOT_ROM_SPAN = 32'h00010000;
	localparam logic [31:0] SDI_ROM_IMG_MASK = 32'h00000fff;
	localparam logic [31:0] SDI_RUN_ROM_BASE = 32'h00010000;
	localparam logic [31:0] SDI_RST_FL_BASE = 32'h00010000;
	localparam logic [31:0] SDI_RUN_FL_BASE = 32'h00000000;
	localparam logic [31:0] SDI_RAM_BASE = 32'h00019000;
	localparam logic [4:0] SDI_SZ_4K = 5'h02;
	localparam logic [4:0] SDI_SZ_32K = 5'h05;
	localparam logic [4:0] SDI_SZ_MAX = 5'h0e;
	localparam int SDI_SZ_LOG_MIN = 10;
	// control loop peripherals
	localparam logic [31:0] SDI_PER_FIRST = 32'h00020000;
	localparam logic [31:0] SDI_PER_STEP = 32'h00010000;
	localparam logic [31:0] SDI_PER_WIN_MASK = 32'h000000ff;
	localparam int SDI_PER_N = 13;
	// peripheral selects, 1 kB each
	localparam logic [31:0] SDI_PSEL_BASE = 32'hfff7e000;
	localparam int SDI_PSEL_LOG = 10;
	localparam int SDI_PSEL_N = 8;
	localparam logic [3:0] SDI_WAIT_RST = 4'h1;
	localparam logic [4:0] SDI_CH_BROWNOUT = 5'h00;
	localparam logic [4:0] SDI_CH_WATCHDOG = 5'h02;
	localparam logic [1:0] SDI_RESP_OKAY = 2'h0;
	localparam logic [1:0] SDI_RESP_SLVERR = 2'h2;

	// cpu side access request
	typedef struct packed {
		logic req;
		logic wr;
		logic priv;
		logic [31:0] addr;
	} sdi_cpu_req_t;

	// bus engine states
	typedef enum logic [3:0] {
		SDI_IDLE = 4'h1,
		SDI_WAIT = 4'h2,
		SDI_BRESP = 4'h4,
		SDI_RRESP = 4'h8
	} sdi_state_t;
endpackage

// ### verilog/sdi_system_module.sv
// system decode and interrupt block: address decode, access protection, 32 channel interrupts
// assumes the cpu holds its request until ack and clears serviced pending bits itself
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module sdi_system_module #(
	parameter int NCH = 32,
	parameter int PWAIT_W = 4
) (
	input wire logic clk,
	input wire logic arst_n,
	// axi4-lite slave
	input wire logic [31:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [31:0] s_araddr,
	input wire logic [2:0] s_arprot,
	input wire logic [2:0] s_awprot,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// cpu access decode port
	input wire sdi_pkg::sdi_cpu_req_t cpu_req,
	output logic cpu_wait,
	output logic sel_flash,
	output logic sel_rom,
	output logic sel_ram,
	output logic [12:0] sel_loop_per,
	output logic [7:0] sel_periph,
	output logic access_fault,
	output logic access_reset,
	output logic [2:0] clk_speed,
	// interrupt requests and outputs
	input wire logic [31:0] irq_src,
	output logic fiq_n,
	output logic irq_n
);
	// =====================================================
	// configuration registers
	logic [31:0] fl_base_ff, nxt_fl_base;
	logic [31:0] rom_base_ff, nxt_rom_base;
	logic [31:0] ram_base_ff, nxt_ram_base;
	logic [4:0] fl_sz_ff, nxt_fl_sz, rom_sz_ff, nxt_rom_sz, ram_sz_ff, nxt_ram_sz;
	logic run_map_ff, nxt_run_map;
	logic [15:0] user_ok_ff, nxt_user_ok;
	logic fault_to_reset_ff, nxt_fault_to_reset;
	logic [2:0] clk_speed_ff, nxt_clk_speed;
	logic [PWAIT_W-1:0] pwait_ff, nxt_pwait;
	logic [NCH-1:0] pend_ff, nxt_pend, mask_ff, nxt_mask, fiqsel_ff, nxt_fiqsel;
	logic [NCH-1:0] src_s1_ff, src_s2_ff;
	sdi_pkg::sdi_state_t st_ff, nxt_st;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0] resp_ff, nxt_resp;
	logic [3:0] wcnt_ff, nxt_wcnt;
	logic wr_ff, nxt_wr;
	logic [31:0] waddr_ff, nxt_waddr, wdata_ff, nxt_wdata;
	logic wpriv_ff, nxt_wpriv;
	logic [PWAIT_W-1:0] pcnt_ff, nxt_pcnt;
	logic fault_ff, nxt_fault, rstreq_ff, nxt_rstreq;

	// =====================================================
	// region match helper
	function automatic logic in_region(input logic [31:0] a, input logic [31:0] b,
			input logic [4:0] sz);
		logic [31:0] m;
		m = (32'h00000001 << (sz + 5'(sdi_pkg::SDI_SZ_LOG_MIN))) - 32'h00000001;
		in_region = ((a & ~m) == (b & ~m));
	endfunction

	// =====================================================
	// cpu address decode
	logic dec_any, dec_hit_regs, priv_ok;
	logic [NCH-1:0] req_vec;
	always_comb begin
		sel_flash = 1'b0;
		sel_rom = 1'b0;
		sel_ram = 1'b0;
		sel_loop_per = '0;
		sel_periph = '0;
		dec_hit_regs = 1'b0;
		priv_ok = 1'b1;
		if (cpu_req.req) begin
			if (!run_map_ff && cpu_req.addr < sdi_pkg::SDI_BOOT_ROM_SPAN)
				sel_rom = 1'b1;
			else if (in_region(cpu_req.addr, rom_base_ff, rom_sz_ff))
				sel_rom = 1'b1;
			else if (in_region(cpu_req.addr, fl_base_ff, fl_sz_ff))
				sel_flash = 1'b1;
			else if (in_region(cpu_req.addr, ram_base_ff, ram_sz_ff))
				sel_ram = 1'b1;
			// 256 byte windows at 64K steps
			for (int i = 0; i < sdi_pkg::SDI_PER_N; i++) begin
				if ((cpu_req.addr & ~sdi_pkg::SDI_PER_WIN_MASK) ==
						sdi_pkg::SDI_PER_FIRST + 32'(i) * sdi_pkg::SDI_PER_STEP)
					sel_loop_per[i] = 1'b1;
			end
			if ((cpu_req.addr >> (sdi_pkg::SDI_PSEL_LOG + 3)) ==
					(sdi_pkg::SDI_PSEL_BASE >> (sdi_pkg::SDI_PSEL_LOG + 3)))
				sel_periph[cpu_req.addr[12:10]] = 1'b1;
			// decoder registers at top; the interrupt window is matched in dec_any
			if (cpu_req.addr[31:8] == sdi_pkg::SDI_DEC_BASE[31:8])
				dec_hit_regs = 1'b1;
			if (!cpu_req.priv) begin
				if (sel_flash) priv_ok = user_ok_ff[0];
				if (sel_rom) priv_ok = user_ok_ff[1];
				if (sel_ram) priv_ok = user_ok_ff[2];
				if (|sel_periph) priv_ok = user_ok_ff[3];
				if (|sel_loop_per) priv_ok = user_ok_ff[4];
			end
		end
	end
	assign dec_any = sel_flash | sel_rom | sel_ram | (|sel_loop_per) | (|sel_periph) |
		dec_hit_regs | ((cpu_req.addr >= sdi_pkg::SDI_CIM_LO) &&
		(cpu_req.addr <= sdi_pkg::SDI_CIM_HI));

	// =====================================================
	// cpu wait and fault generation
	// wait cycles owed by the current access; counting up lets the first cycle wait already
	logic [PWAIT_W-1:0] need_wait;
	assign need_wait = dec_hit_regs ? PWAIT_W'(sdi_pkg::SDI_WAIT_RST) :
		((|sel_periph) ? pwait_ff : '0);
	always_comb begin
		nxt_pcnt = '0;
		nxt_fault = 1'b0;
		nxt_rstreq = rstreq_ff;
		// stretch peripheral cycles, count clears once the access completes
		if (cpu_req.req && pcnt_ff < need_wait)
			nxt_pcnt = pcnt_ff + 1'b1;
		// fault or reset on bad access
		if (cpu_req.req && (!dec_any || !priv_ok)) begin
			nxt_fault = !fault_to_reset_ff;
			nxt_rstreq = fault_to_reset_ff;
		end
	end
	// wait state on decoder register access and on peripheral select access
	assign cpu_wait = cpu_req.req && (pcnt_ff < need_wait);
	assign access_fault = fault_ff;
	assign access_reset = rstreq_ff;
	assign clk_speed = clk_speed_ff;

	// =====================================================
	// interrupt channels
	// sources are asynchronous, two stages before use
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			src_s1_ff <= '0;
			src_s2_ff <= '0;
		end else begin
			src_s1_ff <= irq_src;
			src_s2_ff <= src_s1_ff;
		end
	end
	// channel n fed by source n, brownout 0 and watchdog 2
	assign req_vec = src_s2_ff;

	function automatic logic [5:0] top_chan(input logic [NCH-1:0] v);
		logic [5:0] r;
		r = 6'h00;
		for (int i = 0; i < NCH; i++)
			if (v[i]) r = {1'b1, 5'(i)};
		top_chan = r;
	endfunction
	logic [NCH-1:0] act_fiq, act_irq;
	logic [5:0] fiq_vec, irq_vec;
	assign act_fiq = pend_ff & mask_ff & fiqsel_ff;
	assign act_irq = pend_ff & mask_ff & ~fiqsel_ff;
	// vector index, zero when none pending
	assign fiq_vec = top_chan(act_fiq);
	assign irq_vec = top_chan(act_irq);
	assign fiq_n = ~(|act_fiq);
	assign irq_n = ~((|act_irq) && !(|act_fiq));

	// =====================================================
	// axi4-lite engine and register writes
	logic aw_take, ar_take;
	assign s_awready = (st_ff == sdi_pkg::SDI_IDLE) && s_wvalid && !s_arvalid;
	assign s_wready = s_awready && s_awvalid;
	assign s_arready = (st_ff == sdi_pkg::SDI_IDLE);
	assign aw_take = s_awvalid && s_wready;
	assign ar_take = s_arvalid && s_arready;
	assign s_bvalid = (st_ff == sdi_pkg::SDI_BRESP);
	assign s_rvalid = (st_ff == sdi_pkg::SDI_RRESP);
	assign s_bresp = resp_ff;
	assign s_rresp = resp_ff;
	assign s_rdata = rdata_ff;

	always_comb begin
		logic [7:0] ofs;
		logic isdec;
		ofs = waddr_ff[7:0];
		isdec = (waddr_ff[31:8] == sdi_pkg::SDI_DEC_BASE[31:8]);
		nxt_st = st_ff;
		nxt_wcnt = wcnt_ff;
		nxt_wr = wr_ff;
		nxt_waddr = waddr_ff;
		nxt_wdata = wdata_ff;
		nxt_wpriv = wpriv_ff;
		nxt_rdata = rdata_ff;
		nxt_resp = resp_ff;
		nxt_fl_base = fl_base_ff;
		nxt_rom_base = rom_base_ff;
		nxt_ram_base = ram_base_ff;
		nxt_fl_sz = fl_sz_ff;
		nxt_rom_sz = rom_sz_ff;
		nxt_ram_sz = ram_sz_ff;
		nxt_run_map = run_map_ff;
		nxt_user_ok = user_ok_ff;
		nxt_fault_to_reset = fault_to_reset_ff;
		nxt_clk_speed = clk_speed_ff;
		nxt_pwait = pwait_ff;
		nxt_mask = mask_ff;
		nxt_fiqsel = fiqsel_ff;
		nxt_pend = pend_ff;
		unique case (st_ff)
			sdi_pkg::SDI_IDLE: begin
				if (s_arvalid) begin
					nxt_wr = 1'b0;
					nxt_waddr = s_araddr;
					nxt_wpriv = s_arprot[0];
					nxt_wcnt = sdi_pkg::SDI_WAIT_RST;
					nxt_st = sdi_pkg::SDI_WAIT;
				end else if (aw_take) begin
					nxt_wr = 1'b1;
					nxt_waddr = s_awaddr;
					nxt_wdata = s_wdata;
					nxt_wpriv = s_awprot[0];
					nxt_wcnt = sdi_pkg::SDI_WAIT_RST;
					nxt_st = sdi_pkg::SDI_WAIT;
				end
			end
			sdi_pkg::SDI_WAIT: begin
				nxt_resp = sdi_pkg::SDI_RESP_OKAY;
				nxt_rdata = 32'h00000000;
				if (!isdec && waddr_ff[31:8] != sdi_pkg::SDI_CIM_BASE[31:8])
					nxt_resp = sdi_pkg::SDI_RESP_SLVERR;
				if (wr_ff) begin
					nxt_st = sdi_pkg::SDI_BRESP;
					if (isdec && wpriv_ff) begin
						unique case (ofs)
							sdi_pkg::SDI_OFS_FLBASE: nxt_fl_base = wdata_ff;
							sdi_pkg::SDI_OFS_ROMBASE: nxt_rom_base = wdata_ff;
							sdi_pkg::SDI_OFS_RAMBASE: nxt_ram_base = wdata_ff;
							sdi_pkg::SDI_OFS_SIZES: begin
								nxt_fl_sz = (wdata_ff[4:0] > sdi_pkg::SDI_SZ_MAX) ?
									sdi_pkg::SDI_SZ_MAX : wdata_ff[4:0];
								nxt_rom_sz = (wdata_ff[12:8] > sdi_pkg::SDI_SZ_MAX) ?
									sdi_pkg::SDI_SZ_MAX : wdata_ff[12:8];
								nxt_ram_sz = (wdata_ff[20:16] > sdi_pkg::SDI_SZ_MAX) ?
									sdi_pkg::SDI_SZ_MAX : wdata_ff[20:16];
								nxt_run_map = wdata_ff[31];
							end
							sdi_pkg::SDI_OFS_PRIV: nxt_user_ok = wdata_ff[15:0];
							sdi_pkg::SDI_OFS_FAULT: begin
								nxt_fault_to_reset = wdata_ff[0];
								nxt_clk_speed = wdata_ff[6:4];
								nxt_pwait = wdata_ff[8 +: PWAIT_W];
							end
							default: ;
						endcase
					end else if (isdec) begin
						nxt_resp = sdi_pkg::SDI_RESP_SLVERR;
					end else if (ofs == sdi_pkg::SDI_OFS_MASK) begin
						nxt_mask = wdata_ff;
					end else if (ofs == sdi_pkg::SDI_OFS_FIQSEL) begin
						nxt_fiqsel = wdata_ff;
					end
				end else begin
					nxt_st = sdi_pkg::SDI_RRESP;
					if (isdec) begin
						unique case (ofs)
							sdi_pkg::SDI_OFS_FLBASE: nxt_rdata = fl_base_ff;
							sdi_pkg::SDI_OFS_ROMBASE: nxt_rdata = rom_base_ff;
							sdi_pkg::SDI_OFS_RAMBASE: nxt_rdata = ram_base_ff;
							sdi_pkg::SDI_OFS_SIZES: nxt_rdata = {run_map_ff, 10'h000,
								ram_sz_ff, 3'h0, rom_sz_ff, 3'h0, fl_sz_ff};
							sdi_pkg::SDI_OFS_PRIV: nxt_rdata = {16'h0000, user_ok_ff};
							sdi_pkg::SDI_OFS_FAULT: nxt_rdata = {20'h00000,
								PWAIT_W'(pwait_ff), 1'b0, clk_speed_ff, 3'h0,
								fault_to_reset_ff};
							default: ;
						endcase
					end else begin
						unique case (ofs)
							sdi_pkg::SDI_OFS_PEND: nxt_rdata = pend_ff;
							sdi_pkg::SDI_OFS_MASK: nxt_rdata = mask_ff;
							sdi_pkg::SDI_OFS_FIQSEL: nxt_rdata = fiqsel_ff;
							sdi_pkg::SDI_OFS_FIQVEC: nxt_rdata = {26'h0, fiq_vec};
							sdi_pkg::SDI_OFS_IRQVEC: nxt_rdata = {26'h0, irq_vec};
							default: ;
						endcase
					end
				end
			end
			sdi_pkg::SDI_BRESP: if (s_bready) nxt_st = sdi_pkg::SDI_IDLE;
			sdi_pkg::SDI_RRESP: if (s_rready) nxt_st = sdi_pkg::SDI_IDLE;
		endcase
		// write one clears, a new request wins
		if (st_ff == sdi_pkg::SDI_WAIT && wr_ff && !isdec && ofs == sdi_pkg::SDI_OFS_PEND)
			nxt_pend = pend_ff & ~wdata_ff;
		nxt_pend = nxt_pend | req_vec;
	end

	// =====================================================
	// state registers
	// reset returns to rom execution map
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= sdi_pkg::SDI_IDLE;
			fl_base_ff <= sdi_pkg::SDI_RST_FL_BASE;
			rom_base_ff <= sdi_pkg::SDI_BOOT_ROM_BASE;
			ram_base_ff <= sdi_pkg::SDI_RAM_BASE;
			fl_sz_ff <= sdi_pkg::SDI_SZ_32K;
			rom_sz_ff <= sdi_pkg::SDI_SZ_4K;
			ram_sz_ff <= sdi_pkg::SDI_SZ_4K;
			run_map_ff <= 1'b0;
			user_ok_ff <= 16'hffff;
			fault_to_reset_ff <= 1'b0;
			clk_speed_ff <= 3'h0;
			pwait_ff <= '0;
			pend_ff <= '0;
			mask_ff <= '0;
			fiqsel_ff <= '0;
			rdata_ff <= 32'h00000000;
			resp_ff <= sdi_pkg::SDI_RESP_OKAY;
			wcnt_ff <= 4'h0;
			wr_ff <= 1'b0;
			waddr_ff <= 32'h00000000;
			wdata_ff <= 32'h00000000;
			wpriv_ff <= 1'b0;
			pcnt_ff <= '0;
			fault_ff <= 1'b0;
			rstreq_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			fl_base_ff <= nxt_fl_base;
			rom_base_ff <= nxt_rom_base;
			ram_base_ff <= nxt_ram_base;
			fl_sz_ff <= nxt_fl_sz;
			rom_sz_ff <= nxt_rom_sz;
			ram_sz_ff <= nxt_ram_sz;
			run_map_ff <= nxt_run_map;
			user_ok_ff <= nxt_user_ok;
			fault_to_reset_ff <= nxt_fault_to_reset;
			clk_speed_ff <= nxt_clk_speed;
			pwait_ff <= nxt_pwait;
			pend_ff <= nxt_pend;
			mask_ff <= nxt_mask;
			fiqsel_ff <= nxt_fiqsel;
			rdata_ff <= nxt_rdata;
			resp_ff <= nxt_resp;
			wcnt_ff <= nxt_wcnt;
			wr_ff <= nxt_wr;
			waddr_ff <= nxt_waddr;
			wdata_ff <= nxt_wdata;
			wpriv_ff <= nxt_wpriv;
			pcnt_ff <= nxt_pcnt;
			fault_ff <= nxt_fault;
			rstreq_ff <= nxt_rstreq;
		end
	end
endmodule // sdi_system_module

// ### verif/sdi_system_module_props.sv
// checker for the system decode and interrupt block, bound to its top module
// assumes one clock domain and the top module port names
`timescale 1ns/10ps
// ==========
// properties
module sdi_props #(
	parameter int NCH = 32,
	parameter int PWAIT_W = 4
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic s_awvalid,
	input wire logic s_awready,
	input wire logic s_wvalid,
	input wire logic s_wready,
	input wire logic s_bvalid,
	input wire logic s_arvalid,
	input wire logic s_arready,
	input wire logic [31:0] s_rdata,
	input wire logic s_rvalid,
	input wire logic s_rready,
	input wire sdi_pkg::sdi_cpu_req_t cpu_req,
	input wire logic cpu_wait,
	input wire logic sel_flash,
	input wire logic sel_rom,
	input wire logic [12:0] sel_loop_per,
	input wire logic [7:0] sel_periph,
	input wire logic access_fault,
	input wire logic access_reset
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic [31:0] a;
	// cpu address, shortened for the decode checks
	assign a = cpu_req.addr;
	// bus answer: taken, one wait cycle, then valid
	sequence rd_take; s_arvalid && s_arready; endsequence
	sequence rd_answer; !s_rvalid ##1 s_rvalid; endsequence
	sequence wr_take; s_awvalid && s_awready && s_wvalid && s_wready; endsequence
	rd_latency_a: assert property (rd_take |=> rd_answer)
		else $error("read answer not on the second edge");
	wr_latency_a: assert property (wr_take |-> ##2 s_bvalid)
		else $error("write answer not on the second edge");
	rd_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
		else $error("read data dropped before taken");
	dec_wait_a: assert property ($rose(cpu_req.req) && a[31:8] == 24'hfffffe |-> cpu_wait)
		else $error("no wait state on decoder access");
	loop_sel_a: assert property (cpu_req.req && a[31:20] == 12'h0 && a[15:8] == 8'h0
		&& a[19:16] >= 4'h2 && a[19:16] <= 4'he |-> sel_loop_per == (13'h1 << (a[19:16] - 4'h2)))
		else $error("loop peripheral select wrong");
	loop_off_a: assert property (a[15:8] != 8'h0 |-> sel_loop_per == 13'h0)
		else $error("loop select outside its window");
	periph_sel_a: assert property (cpu_req.req && a[31:13] == 19'h7ffbf
		|-> sel_periph == (8'h1 << a[12:10]))
		else $error("peripheral select wrong");
	sel_excl_a: assert property (!(sel_flash && sel_rom))
		else $error("flash and rom selected together");
	fault_cause_a: assert property (access_fault |-> $past(cpu_req.req) || $past(cpu_req.req, 2))
		else $error("fault without an access");
	reset_sticky_a: assert property (access_reset |=> access_reset)
		else $error("reset request dropped");
endmodule // sdi_props

bind sdi_system_module sdi_props #(.NCH(NCH), .PWAIT_W(PWAIT_W)) u_props (
	.clk(clk), .arst_n(arst_n), .s_awvalid(s_awvalid), .s_awready(s_awready),
	.s_wvalid(s_wvalid), .s_wready(s_wready), .s_bvalid(s_bvalid), .s_arvalid(s_arvalid),
	.s_arready(s_arready), .s_rdata(s_rdata), .s_rvalid(s_rvalid), .s_rready(s_rready),
	.cpu_req(cpu_req), .cpu_wait(cpu_wait), .sel_flash(sel_flash), .sel_rom(sel_rom),
	.sel_loop_per(sel_loop_per), .sel_periph(sel_periph), .access_fault(access_fault),
	.access_reset(access_reset));

// ### verif/sdi_cpu_model.sv
// processor side model: issues one decode access at a time
// assumes the block drops its wait level in time; a hang is left to the bench timeout
`timescale 1ns/10ps
// ==========
// cpu model
module sdi_cpu_model (
	input wire logic clk,
	input wire logic cpu_wait,
	output sdi_pkg::sdi_cpu_req_t cpu_req
);
	initial cpu_req = '0;
	// request launched just after an edge and held
	task automatic start(input logic [31:0] addr, input logic wr, input logic priv);
		@(posedge clk);
		cpu_req <= '{req: 1'b1, wr: wr, priv: priv, addr: addr};
	endtask
	// held until wait is sampled low; the released address lines show the inverse
	task automatic finish();
		do begin
			@(posedge clk);
		end while (cpu_wait);
		cpu_req <= '{req: 1'b0, wr: 1'b0, priv: 1'b0, addr: ~cpu_req.addr};
	endtask
endmodule // sdi_cpu_model

// ### verif/sdi_system_module_tb.sv
// bench for the system decode and interrupt block: decode rows, then bus, fault, irq cases
// assumes the cpu model and the bound checker are compiled alongside
`timescale 1ns/10ps
// ==========
// bench top
module sdi_system_module_tb;
	localparam logic [31:0] DEC = sdi_pkg::SDI_DEC_BASE;
	localparam logic [31:0] CENTRAL_INTERRUPT_MODULE = sdi_pkg::SDI_CIM_BASE;
	localparam logic [1:0] OK = sdi_pkg::SDI_RESP_OKAY;
	localparam logic [1:0] ERR = sdi_pkg::SDI_RESP_SLVERR;
	// decode case: map phase, address, {flash, rom, ram, loop[12:0], periph[7:0]}
	typedef struct packed {
		logic run;
		logic [31:0] addr;
		logic [23:0] sel;
	} sdi_row_t;
	sdi_row_t rows[15] = '{
		'{1'b0, 32'h00000000, 24'h400000}, '{1'b0, 32'h0000f004, 24'h400000},
		'{1'b0, 32'h00010000, 24'h800000}, '{1'b0, 32'h00017ffc, 24'h800000},
		'{1'b0, 32'h00019ffc, 24'h200000}, '{1'b0, 32'h00020000, 24'h000100},
		'{1'b0, 32'h000e00fc, 24'h100000}, '{1'b0, 32'h00030100, 24'h000000},
		'{1'b0, 32'hfff7e000, 24'h000001}, '{1'b0, 32'hfff7fc00, 24'h000080},
		'{1'b1, 32'h00000000, 24'h800000}, '{1'b1, 32'h00007ffc, 24'h800000},
		'{1'b1, 32'h00010ffc, 24'h400000}, '{1'b1, 32'h00008000, 24'h000000},
		'{1'b1, 32'h00019000, 24'h200000}};
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
	logic [2:0] s_awprot = '0, s_arprot = '0;
	logic [31:0] s_awaddr = '0, s_wdata = '0, s_araddr = '0, irq_src = '0;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, cpu_wait, sel_flash, sel_rom;
	logic sel_ram, access_fault, access_reset, fiq_n, irq_n;
	logic [1:0] s_bresp, s_rresp;
	logic [31:0] s_rdata;
	logic [12:0] sel_loop_per;
	logic [7:0] sel_periph;
	logic [2:0] clk_speed;
	sdi_pkg::sdi_cpu_req_t cpu_req;
	int errors = 0, compares = 0, cycles = 0, faults = 0, f;

	sdi_system_module uut (.clk(clk), .arst_n(arst_n), .s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hf),
		.s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arprot(s_arprot), .s_awprot(s_awprot),
		.s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
		.s_rvalid(s_rvalid), .s_rready(s_rready), .cpu_req(cpu_req), .cpu_wait(cpu_wait),
		.sel_flash(sel_flash), .sel_rom(sel_rom), .sel_ram(sel_ram),
		.sel_loop_per(sel_loop_per), .sel_periph(sel_periph), .access_fault(access_fault),
		.access_reset(access_reset), .clk_speed(clk_speed), .irq_src(irq_src),
		.fiq_n(fiq_n), .irq_n(irq_n));
	sdi_cpu_model cpu (.clk(clk), .cpu_wait(cpu_wait), .cpu_req(cpu_req));

	// 50 MHz clock
	always #10 clk = ~clk;

	// cycle ceiling, a hang counts as a mismatch; fault pulses counted
	always @(posedge clk) begin
		cycles++;
		if (access_fault === 1'b1) begin
			faults++;
		end
		if (cycles == 5000) begin
			errors++;
			wrap_up();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one bus transfer; on reads data is the expected word, checked only on okay
	task automatic axi(input logic wr, input logic [31:0] addr, input logic [31:0] data,
		input logic priv, input logic [1:0] resp);
		@(posedge clk);
		if (wr) begin
			s_awaddr <= addr;
			s_wdata <= data;
			s_awprot <= {2'b00, priv};
			s_awvalid <= 1'b1;
			s_wvalid <= 1'b1;
			s_bready <= 1'b1;
			do @(posedge clk); while (!(s_awready && s_wready));
			s_awvalid <= 1'b0;
			s_wvalid <= 1'b0;
			do @(posedge clk); while (!s_bvalid);
			s_bready <= 1'b0;
			chk("bresp", {30'h0, resp}, {30'h0, s_bresp});
		end else begin
			s_araddr <= addr;
			s_arprot <= {2'b00, priv};
			s_arvalid <= 1'b1;
			s_rready <= 1'b1;
			do @(posedge clk); while (!s_arready);
			s_arvalid <= 1'b0;
			do @(posedge clk); while (!s_rvalid);
			s_rready <= 1'b0;
			chk("rresp", {30'h0, resp}, {30'h0, s_rresp});
			if (resp == OK) begin
				chk("rdata", data, s_rdata);
			end
		end
	endtask

	// cpu access with the selects compared while it is held
	task automatic probe(input logic [31:0] addr, input logic priv, input logic [23:0] exp);
		cpu.start(addr, 1'b0, priv);
		@(negedge clk);
		chk("selects", {8'h0, exp}, {8'h0, sel_flash, sel_rom, sel_ram, sel_loop_per, sel_periph});
		cpu.finish();
	endtask

	task automatic wrap_up();
		if (errors == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ==========
	// main sequence
	initial begin
		tick(8);
		arst_n <= 1'b1;
		tick(1);
		// decode rows: reset map first, then the application map
		for (int p = 0; p < 2; p++) begin
			if (p == 1) begin
				axi(1'b1, DEC, 32'h0, 1'b1, OK);
				axi(1'b1, DEC + 32'h4, 32'h00010000, 1'b1, OK);
				axi(1'b1, DEC + 32'hc, 32'h80020205, 1'b1, OK);
			end
			foreach (rows[i]) begin
				if (rows[i].run == p[0]) begin
					probe(rows[i].addr, 1'b1, rows[i].sel);
				end
			end
		end
		// user write refused, unmapped read refused
		axi(1'b1, DEC, 32'h00004000, 1'b0, ERR);
		axi(1'b0, DEC, 32'h0, 1'b1, OK);
		axi(1'b0, 32'h00001000, 32'h0, 1'b1, ERR);
		// user flash denied, user ram allowed
		axi(1'b1, DEC + 32'h10, 32'h0000001e, 1'b1, OK);
		f = faults;
		probe(32'h00019000, 1'b0, 24'h200000);
		tick(2);
		chk("no_fault", 32'h0, {31'h0, faults > f});
		probe(32'h0, 1'b0, 24'h800000);
		tick(2);
		chk("fault", 32'h1, {31'h0, faults > f});
		// stretch, clock speed, fault raised as reset
		axi(1'b1, DEC + 32'h14, 32'h00000351, 1'b1, OK);
		chk("clk_speed", 32'h5, {29'h0, clk_speed});
		cpu.start(32'hfff7e400, 1'b1, 1'b1);
		@(negedge clk);
		chk("periph_wait", 32'h1, {31'h0, cpu_wait});
		cpu.finish();
		cpu.start(DEC + 32'h10, 1'b0, 1'b1);
		@(negedge clk);
		chk("dec_wait", 32'h1, {31'h0, cpu_wait});
		cpu.finish();
		probe(32'h00008000, 1'b1, 24'h0);
		tick(2);
		chk("reset_req", 32'h1, {31'h0, access_reset});
		// every channel, with all lower channels pending too
		axi(1'b1, CENTRAL_INTERRUPT_MODULE + 32'h24, 32'hffffffff, 1'b1, OK);
		for (int c = 0; c < 32; c++) begin
			irq_src <= (32'h2 << c) - 32'h1;
			tick(4);
			chk("irq_n", 32'h0, {31'h0, irq_n});
			irq_src <= '0;
			axi(1'b0, CENTRAL_INTERRUPT_MODULE + 32'h30, {26'h0, 1'b1, c[4:0]}, 1'b1, OK);
			axi(1'b1, CENTRAL_INTERRUPT_MODULE + 32'h20, 32'hffffffff, 1'b1, OK);
		end
		// fiq routing; masked channel keeps its pending bit
		axi(1'b1, CENTRAL_INTERRUPT_MODULE + 32'h24, 32'h80000005, 1'b1, OK);
		axi(1'b1, CENTRAL_INTERRUPT_MODULE + 32'h28, 32'h80000000, 1'b1, OK);
		irq_src <= 32'h80000025;
		tick(4);
		irq_src <= '0;
		// fiq active holds the irq line off
		chk("lines", 32'h1, {30'h0, fiq_n, irq_n});
		axi(1'b0, CENTRAL_INTERRUPT_MODULE + 32'h2c, 32'h3f, 1'b1, OK);
		axi(1'b0, CENTRAL_INTERRUPT_MODULE + 32'h30, 32'h22, 1'b1, OK);
		axi(1'b0, CENTRAL_INTERRUPT_MODULE + 32'h20, 32'h80000025, 1'b1, OK);
		axi(1'b1, CENTRAL_INTERRUPT_MODULE + 32'h20, 32'h80000000, 1'b1, OK);
		chk("lines", 32'h2, {30'h0, fiq_n, irq_n});
		axi(1'b1, CENTRAL_INTERRUPT_MODULE + 32'h24, 32'h80000025, 1'b1, OK);
		axi(1'b0, CENTRAL_INTERRUPT_MODULE + 32'h30, 32'h25, 1'b1, OK);
		axi(1'b1, CENTRAL_INTERRUPT_MODULE + 32'h20, 32'hffffffff, 1'b1, OK);
		chk("lines", 32'h3, {30'h0, fiq_n, irq_n});
		// second reset restores the rom map and defaults
		arst_n <= 1'b0;
		tick(8);
		arst_n <= 1'b1;
		tick(1);
		chk("after_reset", 32'h0, {28'h0, clk_speed, access_reset});
		axi(1'b0, DEC, 32'h00010000, 1'b1, OK);
		axi(1'b0, DEC + 32'h8, 32'h00019000, 1'b1, OK);
		probe(32'h0, 1'b1, 24'h400000);
		wrap_up();
	end
endmodule // sdi_system_module_tb
